// file: hdl/mac_pkg.sv
// constants, configuration layouts and carrier types for the multiply-accumulate slice
//
// Behaviour
// RULE1: slice works as one 36x36, four 18x18 or eight 9x9 multipliers.
// RULE2: operand signedness may change every cycle and applies to that cycle's operands.
// RULE3: accumulator may switch between adding and subtracting every cycle.
// RULE4: each operand loads either in parallel or serially through a shift chain.
// RULE5: multiply-only element gives A times B with no adder or accumulator.
// RULE6: input, pipeline and output registers are each enabled or bypassed by configuration; in accumulate mode the output register is never bypassed.
// RULE7: each register stage picks one of four clock enables and four resets.
// RULE8: fabric zero-fills narrow unsigned operands up to 9, 18 or 36 bits.
// RULE9: fabric sign-extends narrow signed operands up to 9, 18 or 36 bits.
// RULE10: accumulator wraps on overflow and reports it on an overflow output.
// RULE11: unsigned overflow when the new sum is smaller than the previous accumulator.
// RULE12: signed overflow when like-signed values give a sum of the other sign.
// RULE13: overflow output is a one-cycle pulse per event.
// RULE14: fabric may count overflow pulses to extend the accumulator.
// RULE15: product width is the sum of both operand widths.
package mac_pkg;

  // --------------------------------------------------------------------------
  // datapath geometry
  // --------------------------------------------------------------------------
  localparam int unsigned SEG_N  = 8;             // narrowest lanes per slice
  localparam int unsigned NARROW = 9;             // narrow operand width
  localparam int unsigned SEG_W  = 2 * NARROW;    // narrow product width
  localparam int unsigned OPW    = SEG_N * NARROW; // operand bus width
  localparam int unsigned RES_W  = SEG_N * SEG_W;  // result bus width
  localparam int unsigned ACC_WORDS = 5;          // 32-bit words to read back the result

  // --------------------------------------------------------------------------
  // register map (byte addresses)
  // --------------------------------------------------------------------------
  localparam int unsigned ADDR_W      = 6;
  localparam logic [5:0]  OFF_CFG     = 6'h00;
  localparam logic [5:0]  OFF_CESEL   = 6'h04;
  localparam logic [5:0]  OFF_RSTSEL  = 6'h08;
  localparam logic [5:0]  OFF_STATUS  = 6'h0c;
  localparam logic [5:0]  OFF_IRQ_CLR = 6'h10;
  localparam logic [5:0]  OFF_IRQ_EN  = 6'h14;
  localparam logic [5:0]  OFF_ACC0    = 6'h18;    // result words follow at +4 each

  // --------------------------------------------------------------------------
  // configuration layouts
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_9  = 2'b00,
    MODE_18 = 2'b01,
    MODE_36 = 2'b11
  } mac_width_t;

  typedef struct packed {
    logic       ser_b;      // bit 7: operand b from shift chain
    logic       ser_a;      // bit 6: operand a from shift chain
    logic       out_en;     // bit 5: output register in path
    logic       pipe_en;    // bit 4: pipeline register in path
    logic       in_en;      // bit 3: input register in path
    mac_width_t width;      // bits 2:1: lane width
    logic       accumulate; // bit 0: 1 accumulate, 0 multiply-only element
  } mac_cfg_t;

  typedef struct packed {
    logic [1:0] out_sel;    // bits 5:4
    logic [1:0] pipe_sel;   // bits 3:2
    logic [1:0] in_sel;     // bits 1:0
  } mac_sel_t;

  localparam int unsigned CFG_W = $bits(mac_cfg_t);
  localparam int unsigned SEL_W = $bits(mac_sel_t);
  localparam logic [7:0]  CFG_RST = 8'h00;
  localparam logic [5:0]  SEL_RST = 6'h00;
  localparam logic [7:0]  IEN_RST = 8'h00;

  // --------------------------------------------------------------------------
  // carriers between register stages
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [OPW-1:0] a;
    logic [OPW-1:0] b;
    logic           sgn;
    logic           sub;
  } mac_opnd_t;

  typedef struct packed {
    logic [RES_W-1:0] p;
    logic             sgn;
    logic             sub;
  } mac_prod_t;

endpackage

// file: hdl/mac_slice.sv
// multiply-accumulate slice: lanes, stage registers, accumulator and register port
`timescale 1ns/1ns
`default_nettype none

module mac_slice (
  input  wire logic                       i_clk,       // system clock, 25 MHz
  input  wire logic                       i_rstn,      // async reset, active low
  input  wire logic                       i_ce,        // global enable, low freezes all
  input  wire logic [mac_pkg::ADDR_W-1:0] i_addr,      // register byte address
  input  wire logic [31:0]                i_wdata,     // register write data
  input  wire logic                       i_wr,        // register write strobe
  input  wire logic                       i_rd,        // register read strobe
  output logic      [31:0]                o_rdata,     // read data, cycle after i_rd
  input  wire logic [mac_pkg::OPW-1:0]    i_op_a,      // parallel operand a lanes
  input  wire logic [mac_pkg::OPW-1:0]    i_op_b,      // parallel operand b lanes
  input  wire logic                       i_signed,    // operands are two's complement
  input  wire logic                       i_sub,       // accumulator subtracts
  input  wire logic                       i_ser_a,     // serial bit into operand a chain
  input  wire logic                       i_ser_b,     // serial bit into operand b chain
  input  wire logic [3:0]                 i_ce_src,    // four stage clock enables
  input  wire logic [3:0]                 i_rst_src,   // four stage sync resets
  output logic                            o_ser_a,     // operand a chain msb out
  output logic                            o_ser_b,     // operand b chain msb out
  output logic      [mac_pkg::RES_W-1:0]  o_result,    // products or accumulated sums
  output logic      [mac_pkg::SEG_N-1:0]  o_overflow,  // per-lane overflow pulse
  output logic                            o_irq        // enabled overflow pending
);

  // --------------------------------------------------------------------------
  // register port
  // --------------------------------------------------------------------------
  mac_pkg::mac_cfg_t            cfg_r;
  mac_pkg::mac_sel_t            cesel_r;
  mac_pkg::mac_sel_t            rstsel_r;
  logic [mac_pkg::SEG_N-1:0]    status_r;
  logic [mac_pkg::SEG_N-1:0]    irq_en_r;
  logic [mac_pkg::SEG_N-1:0]    clr_c;
  logic [mac_pkg::RES_W-1:0]    acc_r;
  logic [mac_pkg::ACC_WORDS*32-1:0] acc_ext;
  logic [31:0]                  rdata_nxt;

  // configuration writes steer the datapath from the next edge
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      cfg_r    <= mac_pkg::mac_cfg_t'(mac_pkg::CFG_RST);
      cesel_r  <= mac_pkg::mac_sel_t'(mac_pkg::SEL_RST);
      rstsel_r <= mac_pkg::mac_sel_t'(mac_pkg::SEL_RST);
      irq_en_r <= mac_pkg::IEN_RST;
    end
    else if (i_ce && i_wr)
    begin
      case (i_addr)
        mac_pkg::OFF_CFG:    cfg_r    <= mac_pkg::mac_cfg_t'(i_wdata[mac_pkg::CFG_W-1:0]);
        mac_pkg::OFF_CESEL:  cesel_r  <= mac_pkg::mac_sel_t'(i_wdata[mac_pkg::SEL_W-1:0]);
        mac_pkg::OFF_RSTSEL: rstsel_r <= mac_pkg::mac_sel_t'(i_wdata[mac_pkg::SEL_W-1:0]);
        mac_pkg::OFF_IRQ_EN: irq_en_r <= i_wdata[mac_pkg::SEG_N-1:0];
        default:             ;
      endcase
    end
  end

  // write-one-to-clear strobe for the sticky status
  assign clr_c = (i_wr && i_addr == mac_pkg::OFF_IRQ_CLR) ? i_wdata[mac_pkg::SEG_N-1:0] : '0;

  // sticky overflow status; a pulse in the clearing cycle still sets the bit
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      status_r <= '0;
    else if (i_ce)
      status_r <= (status_r & ~clr_c) | o_overflow;
  end

  assign o_irq   = |(status_r & irq_en_r);
  assign acc_ext = {{(mac_pkg::ACC_WORDS * 32 - mac_pkg::RES_W){1'b0}}, acc_r};

  // read mux; unmapped and write-only addresses read as zero
  always_comb
  begin
    rdata_nxt = '0;
    case (i_addr)
      mac_pkg::OFF_CFG:    rdata_nxt[mac_pkg::CFG_W-1:0] = cfg_r;
      mac_pkg::OFF_CESEL:  rdata_nxt[mac_pkg::SEL_W-1:0] = cesel_r;
      mac_pkg::OFF_RSTSEL: rdata_nxt[mac_pkg::SEL_W-1:0] = rstsel_r;
      mac_pkg::OFF_STATUS: rdata_nxt[mac_pkg::SEG_N-1:0] = status_r;
      mac_pkg::OFF_IRQ_EN: rdata_nxt[mac_pkg::SEG_N-1:0] = irq_en_r;
      default:
      begin
        for (int w = 0; w < mac_pkg::ACC_WORDS; w++)
        begin
          if (i_addr == mac_pkg::OFF_ACC0 + 6'(4 * w))
            rdata_nxt = acc_ext[w*32 +: 32];
        end
      end
    endcase
  end

  // read data stands for exactly the cycle after the strobe
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_rdata <= '0;
    else if (i_ce)
      o_rdata <= i_rd ? rdata_nxt : '0;
  end

  // --------------------------------------------------------------------------
  // stage enable and reset selection
  // --------------------------------------------------------------------------
  logic ce_in;
  logic ce_pipe;
  logic ce_out;
  logic rs_in;
  logic rs_pipe;
  logic rs_out;

  // each stage picks its own enable and reset from the shared four
  assign ce_in   = i_ce_src[cesel_r.in_sel];      // see RULE7
  assign ce_pipe = i_ce_src[cesel_r.pipe_sel];    // see RULE7
  assign ce_out  = i_ce_src[cesel_r.out_sel];     // see RULE7
  assign rs_in   = i_rst_src[rstsel_r.in_sel];    // see RULE7
  assign rs_pipe = i_rst_src[rstsel_r.pipe_sel];  // see RULE7
  assign rs_out  = i_rst_src[rstsel_r.out_sel];   // see RULE7

  // --------------------------------------------------------------------------
  // operand loading and input register
  // --------------------------------------------------------------------------
  logic [mac_pkg::OPW-1:0] sreg_a;
  logic [mac_pkg::OPW-1:0] sreg_b;
  mac_pkg::mac_opnd_t      opnd_c;
  mac_pkg::mac_opnd_t      in_r;
  mac_pkg::mac_opnd_t      in_q;

  // serial chains shift one bit per input-stage enable, msb first out
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      sreg_a <= '0;
      sreg_b <= '0;
    end
    else if (i_ce)
    begin
      if (rs_in)
      begin
        sreg_a <= '0;
        sreg_b <= '0;
      end
      else if (ce_in)
      begin
        sreg_a <= {sreg_a[mac_pkg::OPW-2:0], i_ser_a};  // see RULE4
        sreg_b <= {sreg_b[mac_pkg::OPW-2:0], i_ser_b};  // see RULE4
      end
    end
  end

  assign o_ser_a = sreg_a[mac_pkg::OPW-1];
  assign o_ser_b = sreg_b[mac_pkg::OPW-1];

  // signedness and add/sub travel with the operands of the same cycle
  assign opnd_c.a   = cfg_r.ser_a ? sreg_a : i_op_a;  // see RULE4
  assign opnd_c.b   = cfg_r.ser_b ? sreg_b : i_op_b;  // see RULE4
  assign opnd_c.sgn = i_signed;                       // see RULE2
  assign opnd_c.sub = i_sub;                          // see RULE3

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      in_r <= '0;
    else if (i_ce)
    begin
      if (rs_in)
        in_r <= '0;
      else if (ce_in)
        in_r <= opnd_c;
    end
  end

  assign in_q = cfg_r.in_en ? in_r : opnd_c;  // see RULE6

  // --------------------------------------------------------------------------
  // lane multipliers
  // --------------------------------------------------------------------------
  mac_pkg::mac_prod_t prod_c;
  mac_pkg::mac_prod_t pipe_r;
  mac_pkg::mac_prod_t pipe_q;

  // operands arrive already zero-filled or sign-extended to the lane width,
  // so only the lane msb decides the extension here (see RULE8, RULE9)
  always_comb
  begin
    logic [17:0] a9;
    logic [17:0] b9;
    logic [35:0] a18;
    logic [35:0] b18;
    logic [71:0] a36;
    logic [71:0] b36;
    a9  = '0;
    b9  = '0;
    a18 = '0;
    b18 = '0;
    a36 = '0;
    b36 = '0;
    prod_c.p   = '0;
    prod_c.sgn = in_q.sgn;
    prod_c.sub = in_q.sub;
    case (cfg_r.width)
      mac_pkg::MODE_9:
      begin
        for (int i = 0; i < 8; i++)
        begin
          a9 = {{9{in_q.sgn & in_q.a[i*9+8]}}, in_q.a[i*9 +: 9]};  // see RULE2
          b9 = {{9{in_q.sgn & in_q.b[i*9+8]}}, in_q.b[i*9 +: 9]};
          prod_c.p[i*18 +: 18] = 18'(a9 * b9);  // see RULE1, RULE15
        end
      end
      mac_pkg::MODE_18:
      begin
        for (int i = 0; i < 4; i++)
        begin
          a18 = {{18{in_q.sgn & in_q.a[i*18+17]}}, in_q.a[i*18 +: 18]};  // see RULE2
          b18 = {{18{in_q.sgn & in_q.b[i*18+17]}}, in_q.b[i*18 +: 18]};
          prod_c.p[i*36 +: 36] = 36'(a18 * b18);  // see RULE1, RULE15
        end
      end
      default:
      begin
        a36 = {{36{in_q.sgn & in_q.a[35]}}, in_q.a[35:0]};  // see RULE2
        b36 = {{36{in_q.sgn & in_q.b[35]}}, in_q.b[35:0]};
        prod_c.p[71:0] = 72'(a36 * b36);  // see RULE1, RULE15
      end
    endcase
  end

  // pipeline register between multiplier and accumulator
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      pipe_r <= '0;
    else if (i_ce)
    begin
      if (rs_pipe)
        pipe_r <= '0;
      else if (ce_pipe)
        pipe_r <= prod_c;
    end
  end

  assign pipe_q = cfg_r.pipe_en ? pipe_r : prod_c;  // see RULE6

  // --------------------------------------------------------------------------
  // segmented accumulator
  // --------------------------------------------------------------------------
  logic [mac_pkg::SEG_N-1:0] lane_start;
  logic [mac_pkg::SEG_N-1:0] lane_end;
  logic [mac_pkg::RES_W-1:0] addend;
  logic [mac_pkg::RES_W-1:0] sum_c;
  logic [mac_pkg::SEG_N-1:0] ovf_c;

  // lanes are built from 18-bit segments; carries cross only inside a lane
  always_comb
  begin
    for (int k = 0; k < mac_pkg::SEG_N; k++)
    begin
      case (cfg_r.width)
        mac_pkg::MODE_9:  lane_start[k] = 1'b1;
        mac_pkg::MODE_18: lane_start[k] = (k % 2) == 0;
        default:          lane_start[k] = (k % 4) == 0;  // upper half idles at zero
      endcase
    end
  end

  assign lane_end = {1'b1, lane_start[mac_pkg::SEG_N-1:1]};
  assign addend   = pipe_q.sub ? ~pipe_q.p : pipe_q.p;  // see RULE3

  // subtraction is add of the inverted product with carry-in at lane start;
  // the sum simply wraps, overflow is only reported (see RULE10)
  always_comb
  begin
    logic                         carry;
    logic                         cin;
    logic [mac_pkg::SEG_W:0]      seg;
    logic                         a_msb;
    logic                         b_msb;
    carry = 1'b0;
    cin   = 1'b0;
    seg   = '0;
    a_msb = 1'b0;
    b_msb = 1'b0;
    sum_c = '0;
    ovf_c = '0;
    for (int k = 0; k < mac_pkg::SEG_N; k++)
    begin
      cin   = lane_start[k] ? pipe_q.sub : carry;
      seg   = {1'b0, acc_r[k*18 +: 18]} + {1'b0, addend[k*18 +: 18]} + {18'h00000, cin};
      carry = seg[mac_pkg::SEG_W];
      a_msb = acc_r[k*18+17];
      b_msb = addend[k*18+17];
      sum_c[k*18 +: 18] = seg[mac_pkg::SEG_W-1:0];
      if (lane_end[k])
      begin
        if (pipe_q.sgn)
          ovf_c[k] = (a_msb == b_msb) && (seg[17] != a_msb);  // see RULE12
        else
          ovf_c[k] = pipe_q.sub ? ~carry : carry;            // see RULE11
      end
    end
    if (cfg_r.width[1]) ovf_c = {ovf_c[3], 7'h00};  // wide lane reports on bit 7, see RULE10
  end

  // output register doubles as the accumulator in accumulate mode;
  // the overflow flag is dropped on the next edge so each event is one pulse
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      acc_r      <= '0;
      o_overflow <= '0;
    end
    else if (i_ce)
    begin
      if (rs_out)
      begin
        acc_r      <= '0;
        o_overflow <= '0;
      end
      else if (ce_out && cfg_r.accumulate)
      begin
        acc_r      <= sum_c;   // see RULE10
        o_overflow <= ovf_c;   // see RULE10, RULE13
      end
      else
      begin
        if (ce_out)
          acc_r <= pipe_q.p;   // see RULE5
        o_overflow <= '0;      // see RULE13
      end
    end
  end

  // the accumulator is always registered; only multiply-only may bypass
  assign o_result = (cfg_r.accumulate || cfg_r.out_en) ? acc_r : pipe_q.p;  // see RULE5, RULE6

endmodule

`default_nettype wire

// file: testbench/mac_slice_props.sv
// concurrent checks on the multiply-accumulate slice ports
`timescale 1ns/1ns
`default_nettype none

module mac_slice_props (
  input wire logic                       i_clk,      // clock
  input wire logic                       i_rstn,     // reset, active low
  input wire logic                       i_ce,       // global enable
  input wire logic [mac_pkg::ADDR_W-1:0] i_addr,     // register address
  input wire logic [31:0]                i_wdata,    // write data
  input wire logic                       i_wr,       // write strobe
  input wire logic                       i_rd,       // read strobe
  input wire logic [31:0]                o_rdata,    // read data
  input wire logic [mac_pkg::OPW-1:0]    i_op_a,     // operand a
  input wire logic [mac_pkg::OPW-1:0]    i_op_b,     // operand b
  input wire logic                       i_signed,   // signed operands
  input wire logic                       i_sub,      // subtract
  input wire logic [3:0]                 i_ce_src,   // stage enables
  input wire logic [3:0]                 i_rst_src,  // stage resets
  input wire logic                       o_ser_a,    // chain a out
  input wire logic                       o_ser_b,    // chain b out
  input wire logic [mac_pkg::RES_W-1:0]  o_result,   // result
  input wire logic [mac_pkg::SEG_N-1:0]  o_overflow, // overflow pulses
  input wire logic                       o_irq       // interrupt
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  // ------------------------------------
  // helper logic
  // ------------------------------------
  mac_pkg::mac_cfg_t cfg_r;
  logic [71:0]       ax;
  logic [71:0]       bx;
  logic [71:0]       p36;
  logic [72:0]       sum;
  logic              run;

  // mirror of the mode word
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      cfg_r <= mac_pkg::CFG_RST;
    else if (i_ce && i_wr && i_addr == mac_pkg::OFF_CFG)
      cfg_r <= i_wdata[7:0];
  end

  // wide-lane product and accumulator sum
  assign ax  = {{36{i_signed & i_op_a[35]}}, i_op_a[35:0]};
  assign bx  = {{36{i_signed & i_op_b[35]}}, i_op_b[35:0]};
  assign p36 = ax * bx;
  assign sum = {1'b0, o_result[71:0]} + {1'b0, p36};
  assign run = cfg_r.accumulate && cfg_r.width == mac_pkg::MODE_36 && !cfg_r.in_en
               && !cfg_r.pipe_en && !cfg_r.ser_a && !cfg_r.ser_b && i_ce
               && i_ce_src == 4'hf && i_rst_src == 4'h0;

  sequence s_add_step;
    run && !i_sub;
  endsequence

  // ------------------------------------
  // properties
  // ------------------------------------
  a_rdata_idle: assert property (!$past(i_rd) && $past(i_ce) |-> o_rdata == 32'h0)
    else $error("read data seen without a read");
  a_stage_reset: assert property ($past(i_ce) && $past(i_rst_src) == 4'hf |-> o_overflow == 8'h00)
    else $error("overflow survives a stage reset");
  a_ce_freeze: assert property (!i_ce |=> $stable(o_overflow) && $stable(o_rdata)
    && $stable({o_ser_a, o_ser_b})) else $error("flops moved while disabled");
  a_multiply_only_element_only: assert property (cfg_r == 8'h06 |-> o_result == {72'h0, p36})
    else $error("multiply-only product wrong");
  a_acc_step: assert property (run |=> o_result == {72'h0, $past(i_sub) ?
    $past(o_result[71:0]) - $past(p36) : $past(o_result[71:0]) + $past(p36)})
    else $error("accumulator step wrong");
  a_unsigned_ovf: assert property (s_add_step ##0 !i_signed |=> o_overflow[7] == $past(sum[72]))
    else $error("unsigned overflow flag wrong");
  a_signed_ovf: assert property (s_add_step ##0 i_signed |=> o_overflow[7] ==
    $past(o_result[71] == p36[71] && sum[71] != o_result[71])) else $error("signed overflow flag wrong");
  a_wide_lanes: assert property ($past(i_ce) && $past(cfg_r.width) == mac_pkg::MODE_36
    && cfg_r.width == mac_pkg::MODE_36 |-> o_overflow[6:0] == 7'h0) else $error("narrow lane flag in wide mode");
  a_irq_rise: assert property ($rose(o_irq) |-> $past(o_overflow) != 8'h00 || $past(i_wr))
    else $error("interrupt without cause");
endmodule

bind mac_slice mac_slice_props i_mac_slice_props (.*);
`default_nettype wire

// file: testbench/mac_fabric_ext.sv
// fabric-side accumulator extension built from overflow pulses
`timescale 1ns/1ns
`default_nettype none

module mac_fabric_ext (
  input  wire logic       i_clk,  // system clock
  input  wire logic       i_rstn, // async reset, active low
  input  wire logic       i_ce,   // global enable of the slice
  input  wire logic       i_ovf,  // top lane overflow pulse
  input  wire logic       i_up,   // slice is adding
  output logic      [7:0] o_ext   // extension bits above the accumulator
);
  // one count per pulse; a held flag would over-count
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_ext <= 8'h00;
    else if (i_ce && i_ovf)
      o_ext <= i_up ? o_ext + 8'h01 : o_ext - 8'h01;
  end
endmodule
`default_nettype wire

// file: testbench/test_mac_slice.sv
// self-checking bench for the multiply-accumulate slice
`timescale 1ns/1ns
`default_nettype none

module test_mac_slice;
  logic         clk;
  logic         rstn;
  logic         ce;
  logic [5:0]   addr;
  logic [31:0]  wdata;
  logic         wr;
  logic         rd;
  logic [31:0]  rdata;
  logic [71:0]  op_a;
  logic [71:0]  op_b;
  logic         sgn;
  logic         sub;
  logic         ser_a;
  logic         ser_b;
  logic [3:0]   ce_src;
  logic [3:0]   rst_src;
  logic [143:0] result;
  logic [7:0]   ovf;
  logic         irq;
  logic [7:0]   ext;
  logic [1:0]   ser_o;
  int           compares = 0;
  int           miscompares = 0;

  mac_slice i_mac_slice (.i_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_op_a(op_a), .i_op_b(op_b), .i_signed(sgn),
    .i_sub(sub), .i_ser_a(ser_a), .i_ser_b(ser_b), .i_ce_src(ce_src), .i_rst_src(rst_src),
    .o_ser_a(ser_o[1]), .o_ser_b(ser_o[0]), .o_result(result), .o_overflow(ovf), .o_irq(irq));
  mac_fabric_ext i_mac_fabric_ext (.i_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_ovf(ovf[7]),
    .i_up(!sub), .o_ext(ext));

  // ------------------------------------
  // helpers
  // ------------------------------------
  task automatic chk(input string what, input logic [143:0] exp, input logic [143:0] got);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // #1 lets registered answers settle before a check
  task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_reg(input logic [5:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // narrow nibble padded up to the lane width, as the fabric must
  function automatic logic [71:0] fill(input logic [3:0] v, input int w, input logic s);
    logic [71:0] r;
    r = '0;
    for (int i = 0; i < 72 / w; i++)
      for (int j = 0; j < w; j++)
        r[w * i + j] = (j < 4) ? v[j] : (s & v[3]);
    return r;
  endfunction

  function automatic logic [143:0] prod(input logic [71:0] a, input logic [71:0] b,
                                        input int w, input logic s);
    logic [143:0] m, ax, bx, r;
    r = '0;
    m = (144'h1 << w) - 144'h1;
    for (int i = 0; i < ((w == 36) ? 1 : 72 / w); i++)
    begin
      ax = (144'(a) >> (w * i)) & m;
      bx = (144'(b) >> (w * i)) & m;
      if (s && ax[w - 1])
        ax = ax | ~m;
      if (s && bx[w - 1])
        bx = bx | ~m;
      r = r | (((ax * bx) & ((144'h1 << (2 * w)) - 144'h1)) << (2 * w * i));
    end
    return r;
  endfunction

  task automatic end_of_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ------------------------------------
  // scenarios
  // ------------------------------------
  task automatic t_regs;
    logic [31:0] d;
    for (int k = 0; k < 64; k += 4)
    begin
      rd_reg(6'(k), d);
      chk("reset register", 144'h0, 144'(d));
    end
    wr_reg(mac_pkg::OFF_STATUS, 32'hff);
    rd_reg(mac_pkg::OFF_STATUS, d);
    chk("read-only status", 144'h0, 144'(d));
    wr_reg(mac_pkg::OFF_CFG, 32'h39);
    rd_reg(mac_pkg::OFF_CFG, d);
    chk("mode word", 144'h39, 144'(d));
  endtask

  task automatic t_multiply_only_element;
    int          w;
    logic [71:0] a;
    logic [71:0] b;
    for (int k = 0; k < 6; k++)
    begin
      w = 9 << (k / 2);
      a = fill(4'ha, w, k[0]);
      b = fill(4'h5, w, k[0]);
      wr_reg(mac_pkg::OFF_CFG, 32'((k / 2) * (k / 2 + 1)));
      @(posedge clk);
      op_a <= a;
      op_b <= b;
      sgn <= k[0];
      #1;
      chk("lane products", prod(a, b, w, k[0]), result);
    end
  endtask

  task automatic t_acc;
    logic [31:0] d;
    wr_reg(mac_pkg::OFF_CFG, 32'h07);
    @(posedge clk);
    rst_src <= 4'hf;
    {op_a, op_b, sgn, sub} <= {72'd3, 72'd4, 2'b00};
    @(posedge clk);
    rst_src <= 4'h0;
    #1;
    chk("cleared sum", 144'h0, result);
    @(posedge clk);
    {ce, sub} <= 2'b01;
    #1;
    chk("added product", 144'd12, result);
    @(posedge clk);
    ce <= 1'b1;
    #1;
    chk("frozen sum", 144'd12, result);
    @(posedge clk);
    {op_a, op_b, sgn, sub} <= {72'hf_ffff_ffff, 72'd1, 2'b10};
    #1;
    chk("subtracted product", 144'h0, result);
    @(posedge clk);
    {op_a, sgn} <= {72'd1, 1'b0};
    #1;
    chk("signed minus one", {72'h0, {72{1'b1}}}, result);
    @(posedge clk);
    op_b <= 72'h0;
    #1;
    chk("wrapped sum", 144'h0, result);
    chk("unsigned overflow", 144'h80, 144'(ovf));
    @(posedge clk);
    #1;
    chk("pulse length", 144'h0, 144'(ovf));
    chk("extension count", 144'h1, 144'(ext));
    chk("masked irq", 144'h0, 144'(irq));
    wr_reg(mac_pkg::OFF_IRQ_EN, 32'h80);
    chk("enabled irq", 144'h1, 144'(irq));
    rd_reg(mac_pkg::OFF_STATUS, d);
    chk("sticky status", 144'h80, 144'(d));
    wr_reg(mac_pkg::OFF_IRQ_CLR, 32'h80);
    chk("cleared irq", 144'h0, 144'(irq));
    // two products of +2**70 pass the signed maximum
    @(posedge clk);
    rst_src <= 4'hf;
    {op_a, op_b, sgn} <= {72'h8_0000_0000, 72'h8_0000_0000, 1'b1};
    @(posedge clk);
    rst_src <= 4'h0;
    repeat (2) @(posedge clk);
    op_b <= 72'h0;
    #1;
    chk("signed wrap", {72'h0, 72'h80_0000_0000_0000_0000}, result);
    chk("signed overflow", 144'h80, 144'(ovf));
  endtask

  task automatic t_stages;
    wr_reg(mac_pkg::OFF_CFG, 32'h3e);
    wr_reg(mac_pkg::OFF_CESEL, 32'h39);
    wr_reg(mac_pkg::OFF_RSTSEL, 32'h20);
    @(posedge clk);
    {op_a, op_b, sgn} <= {72'd7, 72'd6, 1'b0};
    repeat (2) @(posedge clk);
    #1;
    chk("early output", 144'h0, result);
    @(posedge clk);
    {ce_src, op_a} <= {4'h7, 72'd1};
    #1;
    chk("three-stage product", 144'd42, result);
    repeat (3) @(posedge clk);
    rst_src <= 4'h4;
    #1;
    chk("held output", 144'd42, result);
    @(posedge clk);
    {rst_src, ce_src} <= {4'h0, 4'hf};
    #1;
    chk("selected reset", 144'h0, result);
  endtask

  task automatic t_serial;
    logic [71:0] va;
    logic [71:0] vb;
    va = {1'b1, 71'd5};
    vb = 72'd3;
    wr_reg(mac_pkg::OFF_CFG, 32'hc6);
    for (int k = 71; k >= 0; k--)
    begin
      @(posedge clk);
      {ser_a, ser_b} <= {va[k], vb[k]};
    end
    @(posedge clk);
    #1;
    chk("serial product", 144'd15, result);
    chk("chain msbs", 144'h2, 144'(ser_o));
  endtask

  // ------------------------------------
  // clock, reset, sequence and watchdog
  // ------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial
  begin
    {rstn, ce, addr, wdata, wr, rd, op_a, op_b} = '0;
    {sgn, sub, ser_a, ser_b, rst_src} = '0;
    ce_src = 4'hf;
    ce = 1'b1;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_multiply_only_element();
    t_acc();
    t_stages();
    t_serial();
    end_of_test();
  end

  // under two hundred cycles are needed; wide margin
  initial
  begin
    #(40 * 3000);
    miscompares++;
    end_of_test();
  end
endmodule
`default_nettype wire
